// File: hw/wdt_pkg.sv
// Behaviour
// RL1: Mode register accepts only first write.
// RL2: Second mode write raises internal reset.
// RL3: Mode register resets to 67H.
// RL4: Bits 4:3 pick ring, crystal or stop.
// RL5: Bits 2:0 pick period 2^11/2^13 upward.
// RL6: Start on ring oscillator, period code 111.
// RL7: Software writes bits 7:5 as 011.
// RL8: Software writes mode register byte-wide only.
// RL9: Mode write clears the counter.
// RL10: Key ACH to restart clears counter.
// RL11: Other restart values raise internal reset.
// RL12: Single-bit restart access raises internal reset.
// RL13: Restart register always reads 9AH.
// RL14: Fixed option ignores clock select, uses ring.
// RL15: Fixed option never stops, even in STOP.
// RL16: Counter overflow raises internal reset.
// RL17: Stopped counter suppresses misuse resets.
// RL18: Stoppable option holds count in HALT/STOP.
// RL19: Mode write inserts a CPU wait cycle.
// RL20: Watchdog reset sets cause flag bit 4.
// RL21: Reset request is one synchronous pulse.
package wdt_pkg;

    // Register addresses
    localparam logic [15:0] WATCHDOG_MODE_ADDR = 16'hFF98;
    localparam logic [15:0] WATCHDOG_RESTART_KEY_ADDR = 16'hFF99;

    // Reset values and fixed codes
    localparam logic [7:0] WATCHDOG_MODE_RST = 8'h67;
    localparam logic [7:0] RESTART_KEY = 8'hAC;
    localparam logic [7:0] RESTART_READ_VALUE = 8'h9A;
    localparam logic [2:0] MODE_TOP_BITS = 3'h3;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions inside the mode register, and the cause flag bit
    localparam int CLK_SEL_STOP_POS = 4;
    localparam int CLK_SEL_SOURCE_POS = 3;
    localparam int PERIOD_SEL_MSB = 2;
    localparam int CAUSE_FLAG_POS = 4;

    // Period exponents and counter size
    localparam logic [4:0] RING_BASE_EXP = 5'h0B;
    localparam logic [4:0] XTAL_BASE_EXP = 5'h0D;
    localparam int CNT_W = 20;
    localparam logic [4:0] CNT_W_EXP = 5'h14;

    // Crystal enable divider from the system clock
    localparam int XTAL_DIV_DEFAULT = 2;

    // Mode register write lock
    typedef enum logic [1:0] {
        MODE_OPEN = 2'b01,
        MODE_LOCKED = 2'b10
    } mode_lock_e;

    // Reset source codes
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_OVERFLOW = 2'h1;
    localparam logic [1:0] SRC_MISUSE = 2'h2;

endpackage

// File: hw/wdt_ctl_if.sv
`timescale 1ns/100ps
interface wdt_ctl_if;
    logic tick;
    logic clr;
    logic sel_xtal;
    logic [2:0] period;
    logic ovf;

    modport ctl (
        output tick,
        output clr,
        output sel_xtal,
        output period,
        input ovf
    );

    modport cnt (
        input tick,
        input clr,
        input sel_xtal,
        input period,
        output ovf
    );
endinterface

// File: hw/wdt_counter.sv
`timescale 1ns/100ps
module wdt_counter
    import wdt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    wdt_ctl_if.cnt ctl
);

    logic [CNT_W-1:0] count_ff;
    logic ovf_ff;
    logic [CNT_W-1:0] terminal;

    // Last count value of the selected period, 2^n - 1
    function automatic logic [CNT_W-1:0] period_last(
        input logic sel_xtal,
        input logic [2:0] code
    );
        logic [4:0] exp;
        logic [CNT_W-1:0] ones;
        exp = (sel_xtal ? XTAL_BASE_EXP : RING_BASE_EXP) + {2'b00, code};
        ones = '1;
        period_last = ones >> (CNT_W_EXP - exp); // RL5
    endfunction

    assign terminal = period_last(ctl.sel_xtal, ctl.period);

    // Count, clear has priority over a tick
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count_ff <= '0;
        end else if (ctl.clr) begin
            count_ff <= '0; // RL9 RL10
        end else if (ctl.tick) begin
            if (count_ff >= terminal) begin
                count_ff <= '0;
            end else begin
                count_ff <= count_ff + 1'b1;
            end
        end
    end

    // Overflow pulse on the tick that ends the period
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= ctl.tick && !ctl.clr && (count_ff >= terminal); // RL16
        end
    end

    assign ctl.ovf = ovf_ff;

endmodule // wdt_counter

// File: hw/loop_detect_watchdog.sv
`timescale 1ns/100ps
module loop_detect_watchdog
    import wdt_pkg::*;
#(
    parameter bit FIXED_RING_OSC = 1'b0,
    parameter int XTAL_DIV = XTAL_DIV_DEFAULT
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bit_op_i,
    input wire logic [7:0] wdata_i,
    input wire logic ring_osc_i,
    input wire logic halt_i,
    input wire logic stop_i,
    input wire logic cause_clr_i,
    output logic [7:0] rdata_o,
    output logic wait_o,
    output logic rst_req_o,
    output logic [1:0] rst_src_o,
    output logic watchdog_reset_cause_flag_o,
    output logic mode_locked_o,
    output logic running_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////

    localparam int DIV_W = (XTAL_DIV > 1) ? $clog2(XTAL_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(XTAL_DIV - 1);

    wdt_ctl_if ctl_bus ();

    logic [7:0] watchdog_mode_ff;
    logic [7:0] nxt_watchdog_mode;
    mode_lock_e lock_ff;
    logic [2:0] ring_sync_ff;
    logic ring_level_ff;
    logic ring_tick;
    logic [DIV_W-1:0] xtal_div_ff;
    logic xtal_tick;
    logic mode_wr;
    logic restart_wr;
    logic mode_accept;
    logic restart_ok;
    logic misuse;
    logic stopped;
    logic src_xtal;
    logic standby;
    logic [7:0] rdata_ff;
    logic wait_ff;
    logic rst_req_ff;
    logic [1:0] rst_src_ff;
    logic cause_flag_ff;
    logic running_ff;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    ////////////////////////////////////////////////////////////////////////

    // Address match for a register slot
    function automatic logic addr_hit(
        input logic [15:0] addr,
        input logic [15:0] slot
    );
        addr_hit = (addr == slot);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Ring oscillator input
    ////////////////////////////////////////////////////////////////////////

    // Three-stage synchroniser for the free-running oscillator pin
    generate
        for (genvar i = 0; i < 3; i++) begin : g_ring_sync
            if (i == 0) begin : g_first
                always_ff @(posedge clk_sys_i) begin
                    if (rst_i) begin
                        ring_sync_ff[i] <= 1'b0;
                    end else begin
                        ring_sync_ff[i] <= ring_osc_i;
                    end
                end
            end else begin : g_next
                always_ff @(posedge clk_sys_i) begin
                    if (rst_i) begin
                        ring_sync_ff[i] <= 1'b0;
                    end else begin
                        ring_sync_ff[i] <= ring_sync_ff[i-1];
                    end
                end
            end
        end
    endgenerate

    // Accept a new level once stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ring_level_ff <= 1'b0;
        end else if (ring_sync_ff[1] == ring_sync_ff[2]) begin
            ring_level_ff <= ring_sync_ff[2];
        end
    end

    // One tick per accepted rising edge
    assign ring_tick = (ring_sync_ff[1] == ring_sync_ff[2]) &&
                       ring_sync_ff[2] && !ring_level_ff;

    ////////////////////////////////////////////////////////////////////////
    // Crystal clock enable
    ////////////////////////////////////////////////////////////////////////

    // Divider giving one enable pulse per crystal period
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            xtal_div_ff <= '0;
        end else if (xtal_div_ff == DIV_LAST) begin
            xtal_div_ff <= '0;
        end else begin
            xtal_div_ff <= xtal_div_ff + 1'b1;
        end
    end

    assign xtal_tick = (xtal_div_ff == DIV_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Access decode
    ////////////////////////////////////////////////////////////////////////

    // Writes to the two register slots
    assign mode_wr = wr_i && addr_hit(addr_i, WATCHDOG_MODE_ADDR);
    assign restart_wr = wr_i && addr_hit(addr_i, WATCHDOG_RESTART_KEY_ADDR);

    // Only the first mode write after reset takes effect
    assign mode_accept = mode_wr && (lock_ff == MODE_OPEN); // RL1

    // Valid restart: byte access carrying the key
    assign restart_ok = restart_wr && !bit_op_i &&
                        (wdata_i == RESTART_KEY); // RL10

    // Stop field only exists in the stoppable option
    assign stopped = !FIXED_RING_OSC &&
                     watchdog_mode_ff[CLK_SEL_STOP_POS]; // RL4 RL14

    // Crystal source only in the stoppable option
    assign src_xtal = !FIXED_RING_OSC &&
                      watchdog_mode_ff[CLK_SEL_SOURCE_POS]; // RL4 RL14

    // Standby freezes the count only when the option allows it
    assign standby = !FIXED_RING_OSC && (halt_i || stop_i); // RL15 RL18

    // Misuse of either register, silenced while stopped
    always_comb begin
        misuse = 1'b0;
        if (mode_wr && (lock_ff == MODE_LOCKED)) begin
            misuse = 1'b1; // RL2
        end
        if (restart_wr && bit_op_i) begin
            misuse = 1'b1; // RL12
        end
        if (restart_wr && (wdata_i != RESTART_KEY)) begin
            misuse = 1'b1; // RL11
        end
        if (stopped) begin
            misuse = 1'b0; // RL17
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register
    ////////////////////////////////////////////////////////////////////////

    // Value stored by an accepted write
    always_comb begin
        nxt_watchdog_mode = wdata_i;
        if (FIXED_RING_OSC) begin
            nxt_watchdog_mode = {MODE_TOP_BITS, 2'b00,
                                 wdata_i[PERIOD_SEL_MSB:0]}; // RL7 RL14
        end
    end

    // Mode register storage
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            watchdog_mode_ff <= WATCHDOG_MODE_RST; // RL3 RL6
        end else if (mode_accept) begin
            watchdog_mode_ff <= nxt_watchdog_mode; // RL1
        end
    end

    // Write lock closes on the first mode write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            lock_ff <= MODE_OPEN;
        end else begin
            unique case (lock_ff)
                MODE_OPEN: begin
                    if (mode_wr) begin
                        lock_ff <= MODE_LOCKED; // RL1
                    end
                end
                MODE_LOCKED: begin
                    lock_ff <= MODE_LOCKED;
                end
                default: begin
                    lock_ff <= MODE_LOCKED;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter control
    ////////////////////////////////////////////////////////////////////////

    // Tick from the selected source unless stopped or in standby
    assign ctl_bus.tick = !stopped && !standby &&
                          (src_xtal ? xtal_tick : ring_tick); // RL4 RL18
    assign ctl_bus.clr = mode_accept || restart_ok; // RL9 RL10
    assign ctl_bus.sel_xtal = src_xtal;
    assign ctl_bus.period = watchdog_mode_ff[PERIOD_SEL_MSB:0]; // RL5

    // Period counter
    wdt_counter u_counter (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ctl(ctl_bus.cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Reset request and cause
    ////////////////////////////////////////////////////////////////////////

    // Single-cycle reset request to the reset controller
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rst_req_ff <= 1'b0;
        end else begin
            rst_req_ff <= misuse || ctl_bus.ovf; // RL16 RL21
        end
    end

    // Source of the last request, held until reset
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rst_src_ff <= SRC_NONE;
        end else if (ctl_bus.ovf) begin
            rst_src_ff <= SRC_OVERFLOW; // RL21
        end else if (misuse) begin
            rst_src_ff <= SRC_MISUSE; // RL21
        end
    end

    // Cause flag, a new request wins over a clear
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cause_flag_ff <= 1'b0;
        end else if (misuse || ctl_bus.ovf) begin
            cause_flag_ff <= 1'b1; // RL20
        end else if (cause_clr_i) begin
            cause_flag_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // CPU side answers
    ////////////////////////////////////////////////////////////////////////

    // One wait cycle after every mode write
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= mode_wr; // RL19
        end
    end

    // Registered read data
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_ff <= UNMAPPED_READ;
        end else if (rd_i) begin
            if (addr_hit(addr_i, WATCHDOG_MODE_ADDR)) begin
                rdata_ff <= watchdog_mode_ff; // RL1
            end else if (addr_hit(addr_i, WATCHDOG_RESTART_KEY_ADDR)) begin
                rdata_ff <= RESTART_READ_VALUE; // RL13
            end else begin
                rdata_ff <= UNMAPPED_READ;
            end
        end
    end

    // Counter running status
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            running_ff <= 1'b0;
        end else begin
            running_ff <= !stopped && !standby; // RL15 RL18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////

    assign rdata_o = rdata_ff;
    assign wait_o = wait_ff;
    assign rst_req_o = rst_req_ff;
    assign rst_src_o = rst_src_ff;
    assign watchdog_reset_cause_flag_o = cause_flag_ff;
    assign mode_locked_o = lock_ff[1]; // One-hot locked bit
    assign running_o = running_ff;

endmodule // loop_detect_watchdog

// File: tb/wdt_monitor.sv
`timescale 1ns/100ps
module wdt_monitor
    import wdt_pkg::*;
#(
    parameter bit FIXED_RING_OSC = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic bit_op_i,
    input wire logic [7:0] wdata_i,
    input wire logic halt_i,
    input wire logic stop_i,
    input wire logic [7:0] rdata_o,
    input wire logic wait_o,
    input wire logic rst_req_o,
    input wire logic [1:0] rst_src_o,
    input wire logic watchdog_reset_cause_flag_o,
    input wire logic mode_locked_o,
    input wire logic running_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    // Decoded accesses and counting state
    wire wr_mode = wr_i && (addr_i == WATCHDOG_MODE_ADDR);
    wire wr_key = wr_i && (addr_i == WATCHDOG_RESTART_KEY_ADDR);
    wire armed = running_o && !halt_i && !stop_i;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_req_one_cycle: assert property (rst_req_o |=> !rst_req_o)
        else $error("reset request too long");
    a_req_with_cause: assert property (rst_req_o |->
        watchdog_reset_cause_flag_o && rst_src_o != SRC_NONE)
        else $error("request without cause");
    a_mode_wait: assert property (wr_mode |=> wait_o)
        else $error("no wait after mode write");
    a_second_mode: assert property (wr_mode && mode_locked_o && armed
        |=> rst_req_o && rst_src_o == SRC_MISUSE)
        else $error("second mode write not caught");
    a_bad_key: assert property (wr_key && armed &&
        (bit_op_i || wdata_i != RESTART_KEY) |=> rst_req_o)
        else $error("bad key not caught");
    a_stopped_quiet: assert property ((wr_key || wr_mode) &&
        mode_locked_o && !running_o && !$past(halt_i || stop_i) &&
        !halt_i && !stop_i |=> !rst_req_o)
        else $error("misuse reset while stopped");
    a_key_read: assert property (rd_i &&
        addr_i == WATCHDOG_RESTART_KEY_ADDR |=> rdata_o == RESTART_READ_VALUE)
        else $error("key reads wrong");
    a_halt_freeze: assert property (!FIXED_RING_OSC &&
        (halt_i || stop_i) |=> !running_o)
        else $error("count runs in standby");
    a_fixed_runs: assert property (FIXED_RING_OSC &&
        !$past(rst_i) |-> running_o)
        else $error("fixed counter stopped");

    // Main scenarios reached
    c_overflow: cover property (rst_req_o && rst_src_o == SRC_OVERFLOW);
    c_misuse: cover property (rst_req_o && rst_src_o == SRC_MISUSE);
    c_halt: cover property (halt_i ##1 !halt_i);
endmodule // wdt_monitor

bind loop_detect_watchdog wdt_monitor #(
    .FIXED_RING_OSC(FIXED_RING_OSC)
) u_wdt_monitor (
    .clk_sys_i, .rst_i, .addr_i, .wr_i, .rd_i, .bit_op_i, .wdata_i,
    .halt_i, .stop_i, .rdata_o, .wait_o, .rst_req_o, .rst_src_o,
    .watchdog_reset_cause_flag_o, .mode_locked_o, .running_o
);

// File: tb/tb.sv
`timescale 1ns/100ps
module tb
    import wdt_pkg::*;
;
    logic clk_sys_i, rst_i, wr_i, rd_i, bit_op_i, ring_osc_i;
    logic halt_i, stop_i, cause_clr_i, wait_o, rst_req_o;
    logic watchdog_reset_cause_flag_o, mode_locked_o, running_o;
    logic [15:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic [1:0] rst_src_o;
    logic [7:0] rdata_fixed;
    logic [1:0] rst_src_fixed;
    logic rst_req_fixed, running_fixed;
    int mismatches, compares;
    localparam logic [15:0] MA = WATCHDOG_MODE_ADDR;
    localparam logic [15:0] KA = WATCHDOG_RESTART_KEY_ADDR;

    loop_detect_watchdog #(.FIXED_RING_OSC(1'b0), .XTAL_DIV(1))
    u_loop_detect_watchdog (
        .clk_sys_i, .rst_i, .addr_i, .wr_i, .rd_i, .bit_op_i, .wdata_i,
        .ring_osc_i, .halt_i, .stop_i, .cause_clr_i, .rdata_o, .wait_o,
        .rst_req_o, .rst_src_o, .watchdog_reset_cause_flag_o,
        .mode_locked_o, .running_o
    );

    // Second copy built with the fixed oscillator option
    loop_detect_watchdog #(.FIXED_RING_OSC(1'b1), .XTAL_DIV(1))
    u_loop_detect_watchdog_fixed (
        .clk_sys_i, .rst_i, .addr_i, .wr_i, .rd_i, .bit_op_i, .wdata_i,
        .ring_osc_i, .halt_i, .stop_i, .cause_clr_i,
        .rdata_o(rdata_fixed), .wait_o(), .rst_req_o(rst_req_fixed),
        .rst_src_o(rst_src_fixed), .watchdog_reset_cause_flag_o(),
        .mode_locked_o(), .running_o(running_fixed)
    );

    // System clock and free-running ring oscillator, 6 cycles a period
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        ring_osc_i = 1'b0;
        #7;
        forever #150 ring_osc_i = ~ring_osc_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input bit ok, input string m);
        compares++;
        if (!ok) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic rst_dut();
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d, bit b);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        bit_op_i <= b;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        bit_op_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // Idle while no reset request may appear
    task automatic quiet(input int n);
        bit q;
        q = 1'b1;
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
            if (rst_req_o !== 1'b0) q = 1'b0;
        end
        chk(q, "early reset request");
    endtask

    // Cycles until the reset request, bounded
    task automatic wait_req(input int n, output int c);
        c = 0;
        while (rst_req_o !== 1'b1 && c < n) begin
            @(posedge clk_sys_i);
            #1;
            c++;
        end
        if (c >= n) begin
            chk(1'b0, "no reset request");
            tally_and_finish();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        logic [7:0] d;
        rd(MA, d);
        chk(d === WATCHDOG_MODE_RST, "mode reset value");
        rd(KA, d);
        chk(d === RESTART_READ_VALUE, "key read value");
        rd(16'hFF00, d);
        chk(d === UNMAPPED_READ, "unmapped read");
        chk(mode_locked_o === 1'b0, "locked after reset");
        chk(running_o === 1'b1, "not counting");
    endtask

    task automatic t_key();
        wr(KA, RESTART_KEY, 1'b0);
        chk(rst_req_o === 1'b0, "good key reset");
        wr(KA, 8'h55, 1'b0);
        chk(rst_req_o === 1'b1 && rst_src_o === SRC_MISUSE, "bad key");
        chk(watchdog_reset_cause_flag_o === 1'b1, "cause flag");
        @(posedge clk_sys_i);
        cause_clr_i <= 1'b1;
        #1;
        chk(rst_req_o === 1'b0, "long request");
        @(posedge clk_sys_i);
        cause_clr_i <= 1'b0;
        #1;
        chk(watchdog_reset_cause_flag_o === 1'b0, "flag kept");
        wr(KA, RESTART_KEY, 1'b1);
        chk(rst_req_o === 1'b1, "bit access to key");
    endtask

    task automatic t_xtal();
        logic [7:0] d;
        int c, e;
        rst_dut();
        wr(MA, 8'h68, 1'b0);
        chk(wait_o === 1'b1, "no wait cycle");
        chk(mode_locked_o === 1'b1, "mode not locked");
        rd(MA, d);
        chk(d === 8'h68, "mode not stored");
        quiet(4000);
        @(posedge clk_sys_i);
        halt_i <= 1'b1;
        quiet(3000);
        chk(running_o === 1'b0, "count not frozen");
        @(posedge clk_sys_i);
        halt_i <= 1'b0;
        wait_req(4500, c);
        e = (1 << XTAL_BASE_EXP) - 4003;
        chk(c >= e - 8 && c <= e + 8, "held count");
        chk(rst_src_o === SRC_OVERFLOW, "overflow source");
        wr(MA, 8'h67, 1'b0);
        chk(rst_req_o === 1'b1 && rst_src_o === SRC_MISUSE, "rewrite");
        rd(MA, d);
        chk(d === 8'h68, "mode rewritten");
        wr(KA, RESTART_KEY, 1'b0);
        wait_req(9000, c);
        e = 1 << XTAL_BASE_EXP;
        chk(c >= e - 8 && c <= e + 8, "crystal period");
    endtask

    task automatic t_ring();
        int c, e;
        rst_dut();
        wr(MA, 8'h60, 1'b0);
        quiet(6000);
        @(posedge clk_sys_i);
        stop_i <= 1'b1;
        quiet(1000);
        chk(running_o === 1'b0, "count runs in stop");
        @(posedge clk_sys_i);
        stop_i <= 1'b0;
        wait_req(13000, c);
        e = (1 << RING_BASE_EXP) * 6 - 6000;
        chk(c >= e - 16 && c <= e + 16, "ring period held");
    endtask

    // Fixed option: clock field ignored, counts on through STOP
    task automatic t_fixed();
        logic [7:0] d;
        int c, e;
        rst_dut();
        wr(MA, 8'h70, 1'b0);
        rd(MA, d);
        chk(rdata_fixed === 8'h60, "fixed clock field");
        @(posedge clk_sys_i);
        stop_i <= 1'b1;
        c = 0;
        while (rst_req_fixed !== 1'b1 && c < 13000) begin
            @(posedge clk_sys_i);
            #1;
            c++;
        end
        e = (1 << RING_BASE_EXP) * 6 - 3;
        chk(c >= e - 16 && c <= e + 16, "fixed option halted");
        chk(rst_src_fixed === SRC_OVERFLOW, "fixed source");
        chk(running_fixed === 1'b1, "fixed not running");
        if (c >= 13000) begin
            tally_and_finish();
        end
        @(posedge clk_sys_i);
        stop_i <= 1'b0;
    endtask

    task automatic t_stopped();
        logic [7:0] d, v;
        for (int i = 0; i < 2; i++) begin
            v = i ? 8'h78 : 8'h70;
            rst_dut();
            wr(MA, v, 1'b0);
            wr(MA, 8'h67, 1'b0);
            wr(KA, 8'h55, 1'b0);
            wr(KA, RESTART_KEY, 1'b1);
            rd(MA, d);
            chk(d === v && running_o === 1'b0, "stop field");
            chk(watchdog_reset_cause_flag_o === 1'b0, "stopped misuse");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        bit_op_i = 1'b0;
        addr_i = 16'h0000;
        wdata_i = 8'h00;
        halt_i = 1'b0;
        stop_i = 1'b0;
        cause_clr_i = 1'b0;
        mismatches = 0;
        compares = 0;
        rst_dut();
        t_regs();
        t_key();
        t_xtal();
        t_ring();
        t_stopped();
        t_fixed();
        tally_and_finish();
    end
endmodule // tb
